// file: core/serial_unit_pkg.sv
package serial_unit_pkg;
   // Register byte offsets on the bus
   localparam logic [4:0] MODE_OFS  = 5'h00;
   localparam logic [4:0] RATE_OFS  = 5'h04;
   localparam logic [4:0] CTRL_OFS  = 5'h08;
   localparam logic [4:0] TXBUF_OFS = 5'h0c;
   localparam logic [4:0] STAT_OFS  = 5'h10;
   localparam logic [4:0] RXBUF_OFS = 5'h14;
   // Mode register fields
   localparam int MODE_CHR  = 6;
   localparam int MODE_PE   = 5;
   localparam int MODE_ODD  = 4;
   localparam int MODE_STOP = 3;
   localparam int MODE_MP   = 2;
   // Control register fields
   localparam int CTRL_TIE  = 7;
   localparam int CTRL_RIE  = 6;
   localparam int CTRL_TE   = 5;
   localparam int CTRL_RE   = 4;
   localparam int CTRL_MULTIPROC_IRQ_EN = 3;
   localparam int CTRL_TXDONE_IRQ_EN = 2;
   localparam int CTRL_CLK_SRC_SEL_HI = 1;
   localparam int CTRL_CLK_SRC_SEL_LO = 0;
   // Status register fields
   localparam int STAT_TX_BUF_EMPTY_FLAG = 7;
   localparam int STAT_RX_FULL_FLAG = 6;
   localparam int STAT_OVERRUN_FLAG = 5;
   localparam int STAT_FER  = 4;
   localparam int STAT_PER  = 3;
   localparam int STAT_TX_DONE_FLAG = 2;
   localparam int STAT_MPB  = 1;
   localparam int STAT_MPBT = 0;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'hff;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h84;
   // Oversampling: sixteen phases per bit, sample on the eighth
   localparam logic [3:0] SAMPLE_PH = 4'h7;
   localparam logic [3:0] LAST_PH   = 4'hf;

   // Data bits per character from the length select
   function automatic logic [3:0] data_bits(input logic chr);
      return chr ? 4'h7 : 4'h8;
   endfunction : data_bits

   // Parity bit over 7 or 8 data bits, even unless odd is set
   function automatic logic par_bit(input logic [7:0] d,
                                    input logic       chr,
                                    input logic       odd);
      logic [7:0] m;
      m = chr ? {1'b0, d[6:0]} : d;
      return (^m) ^ odd;
   endfunction : par_bit
endpackage : serial_unit_pkg

// file: core/rate_divider.sv
`timescale 1ns/1ps
`default_nettype none
// Internal bit-rate generator: one pulse every reload+1 clocks
module rate_divider
   import serial_unit_pkg::*;
#(
   parameter int W = 8
)(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] reload,
   output logic              tick
);
   logic [W-1:0] cnt;      // Down counter
   logic [W-1:0] next_cnt;

   // Reload on zero so a new reload value applies from the next period
   always_comb
   begin
      tick     = (cnt == '0);
      next_cnt = tick ? reload : cnt - {{(W-1){1'b0}}, 1'b1};
   end

   // Count register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end
endmodule : rate_divider
`default_nettype wire

// file: core/serial_tx.sv
`timescale 1ns/1ps
`default_nettype none
// Transmit framer; advances one bit per bit_tick
module serial_tx
   import serial_unit_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       bit_tick,
   input  wire logic       enable,
   input  wire logic       chr,
   input  wire logic       pe,
   input  wire logic       odd,
   input  wire logic       mp,
   input  wire logic       stop2,
   input  wire logic       mpbt,
   input  wire logic       tx_buf_empty_flag,
   input  wire logic [7:0] tdata,
   output logic            take,
   output logic            done,
   output logic            txd
);
   typedef enum logic [2:0] {
      T_IDLE  = 3'b000,
      T_START = 3'b001,
      T_DATA  = 3'b010,
      T_PAR   = 3'b011,
      T_STOP1 = 3'b100,
      T_STOP2 = 3'b101
   } tx_state_t;

   tx_state_t  st, next_st;      // Frame position
   logic [7:0] sh, next_sh;      // Shift register
   logic [3:0] idx, next_idx;    // Data bit count
   logic       pb, next_pb;      // Parity or multiprocessor bit
   logic       next_txd;
   logic       last_stop;        // Final stop bit of frame

   // Next-state logic for the framer
   always_comb
   begin
      next_st   = st;
      next_sh   = sh;
      next_idx  = idx;
      next_pb   = pb;
      next_txd  = txd;
      take      = 1'b0;
      done      = 1'b0;
      last_stop = (st == T_STOP2) || (st == T_STOP1 && !stop2);
      if (!enable)
      begin
         // Disabled: framer reset, line at mark
         next_st  = T_IDLE;
         next_txd = 1'b1;
      end
      else if (bit_tick && (st == T_IDLE || last_stop))
      begin
         // Buffer checked at end of stop bit for back-to-back frames
         if (!tx_buf_empty_flag)
         begin
            take     = 1'b1;
            next_sh  = tdata;
            next_pb  = mp ? mpbt : par_bit(tdata, chr, odd);
            next_st  = T_START;
            next_txd = 1'b0;
         end
         else
         begin
            done     = (st != T_IDLE);
            next_st  = T_IDLE;
            next_txd = 1'b1;
         end
      end
      else if (bit_tick)
      begin
         case (st)
            T_START:
            begin
               // First data bit, LSB first
               next_st  = T_DATA;
               next_idx = 4'h1;
               next_txd = sh[0];
               next_sh  = {1'b0, sh[7:1]};
            end
            T_DATA:
               if (idx == data_bits(chr))
               begin
                  next_st  = (pe || mp) ? T_PAR : T_STOP1;
                  next_txd = (pe || mp) ? pb : 1'b1;
               end
               else
               begin
                  next_idx = idx + 4'h1;
                  next_txd = sh[0];
                  next_sh  = {1'b0, sh[7:1]};
               end
            T_PAR:
            begin
               next_st  = T_STOP1;
               next_txd = 1'b1;
            end
            T_STOP1:
            begin
               next_st  = T_STOP2;
               next_txd = 1'b1;
            end
            default:
               next_st = T_IDLE;
         endcase
      end
   end

   // Framer registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st  <= T_IDLE;
         sh  <= 8'h00;
         idx <= 4'h0;
         pb  <= 1'b0;
         txd <= 1'b1;
      end
      else
      begin
         st  <= next_st;
         sh  <= next_sh;
         idx <= next_idx;
         pb  <= next_pb;
         txd <= next_txd;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_idle_mark: assert property (st == T_IDLE |-> txd)
      else $error("line not at mark while idle");
   a_stop_high: assert property (st == T_STOP1 |-> txd)
      else $error("stop bit not high");
   a_take_start: assert property (take |=> st == T_START && !txd)
      else $error("load did not start a frame");
endmodule : serial_tx
`default_nettype wire

// file: core/serial_unit.sv
`timescale 1ns/1ps
`default_nettype none
module serial_unit
   import serial_unit_pkg::*;
#(
   parameter int RATE_W = 8   // Bit-rate register width
)(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   output logic             txd_out,
   output logic             txd_oe,
   input  wire logic        rxd_in,
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe,
   output logic             tx_empty_irq,
   output logic             rx_full_irq,
   output logic             rx_error_irq,
   output logic             tx_end_irq
);
   if (RATE_W < 1 || RATE_W > 8)
      $error("RATE_W must be 1 to 8");

   typedef enum logic [2:0] {
      R_IDLE  = 3'b000,
      R_START = 3'b001,
      R_DATA  = 3'b010,
      R_PAR   = 3'b011,
      R_STOP  = 3'b100
   } rx_state_t;

   logic [7:0]        mode_reg, next_mode;      // Frame format
   logic [RATE_W-1:0] bit_rate_reg, next_rate;  // Divider reload
   logic [7:0]        control_reg, next_ctrl;   // Enables, clock select
   logic [7:0]        tx_buffer, next_txbuf;    // Transmit data
   logic [7:0]        rx_buffer, next_rxbuf;    // Received data
   logic [7:0]        status_reg, next_stat;    // Flags
   logic [31:0]       next_rdata;
   logic              next_wait;
   logic              next_irq_te, next_irq_rf, next_irq_re, next_irq_td;
   logic              next_txd_oe;
   logic              wr_ok;                    // Write takes effect now
   logic              err_any;                  // Any receive error

   logic [3:0]        ph, next_ph;              // Phase in the bit
   logic              sck_d, next_sck_d;        // Last external clock
   logic              next_sck_out, next_sck_oe;
   logic              rate_tick;                // Internal 16x pulse
   logic              tick16;                   // Selected 16x pulse
   logic              bit_tick;                 // One per bit time

   rx_state_t         rst, next_rst;            // Receiver position
   logic [3:0]        rcnt, next_rcnt;          // Sixteenth counter
   logic [3:0]        ridx, next_ridx;          // Data bits taken
   logic [7:0]        rx_shift_reg, next_rsh;   // Incoming data
   logic              rpar, next_rpar;          // Parity or mp bit
   logic              fin;                      // Stop bit sampled
   logic              fin_fer, fin_per;         // Frame checks
   logic [7:0]        rx_data;                  // Aligned character

   logic              take;                     // Buffer moved to shifter
   logic              done;                     // Frame ended, no next
   logic              tx_txd;

   // Internal bit-rate generator
   rate_divider #(
      .W      (RATE_W)
   ) u_rate (
      .clk     (clk),
      .reset_n (reset_n),
      .reload  (bit_rate_reg),
      .tick    (rate_tick)
   );

   // Transmit framer
   serial_tx u_tx (
      .clk      (clk),
      .reset_n  (reset_n),
      .bit_tick (bit_tick),
      .enable   (control_reg[CTRL_TE]),
      .chr      (mode_reg[MODE_CHR]),
      .pe       (mode_reg[MODE_PE]),
      .odd      (mode_reg[MODE_ODD]),
      .mp       (mode_reg[MODE_MP]),
      .stop2    (mode_reg[MODE_STOP]),
      .mpbt     (status_reg[STAT_MPBT]),
      .tx_buf_empty_flag     (status_reg[STAT_TX_BUF_EMPTY_FLAG]),
      .tdata    (tx_buffer),
      .take     (take),
      .done     (done),
      .txd      (tx_txd)
   );
   assign txd_out = tx_txd;

   // Clock source and phase; runs whatever the enables say
   always_comb
   begin
      next_sck_d = sck_in;
      // Pins are synchronous, so a registered copy gives the edge
      tick16 = control_reg[CTRL_CLK_SRC_SEL_HI] ? (sck_in && !sck_d)
                                      : rate_tick;
      next_ph  = tick16 ? ph + 4'h1 : ph;
      bit_tick = tick16 && (ph == LAST_PH);
      // Phase 8 is mid-bit, so bit 3 rises at the bit centre
      next_sck_oe  = !control_reg[CTRL_CLK_SRC_SEL_HI]
                     && control_reg[CTRL_CLK_SRC_SEL_LO];
      next_sck_out = next_sck_oe ? ph[3] : 1'b1;
   end

   // Clock registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ph      <= 4'h0;
         sck_d   <= 1'b0;
         sck_out <= 1'b1;
         sck_oe  <= 1'b0;
      end
      else
      begin
         ph      <= next_ph;
         sck_d   <= next_sck_d;
         sck_out <= next_sck_out;
         sck_oe  <= next_sck_oe;
      end
   end

   // Receiver: start detect, centre sampling, checks at stop
   always_comb
   begin
      next_rst  = rst;
      next_rcnt = rcnt;
      next_ridx = ridx;
      next_rsh  = rx_shift_reg;
      next_rpar = rpar;
      fin       = 1'b0;
      fin_fer   = 1'b0;
      fin_per   = 1'b0;
      rx_data   = mode_reg[MODE_CHR] ? {1'b0, rx_shift_reg[7:1]}
                                     : rx_shift_reg;
      if (!control_reg[CTRL_RE])
         next_rst = R_IDLE;       // Flags and buffer left alone
      else if (tick16)
      begin
         next_rcnt = rcnt + 4'h1;
         case (rst)
            R_IDLE:
            begin
               next_rcnt = 4'h0;  // Resynchronise on the fall
               if (!rxd_in && !err_any)
                  next_rst = R_START;
            end
            R_START:
               if (rcnt == SAMPLE_PH)
               begin
                  // A glitch that is high at mid-bit is no start
                  next_rst  = rxd_in ? R_IDLE : R_DATA;
                  next_ridx = 4'h0;
               end
            R_DATA:
               if (rcnt == SAMPLE_PH)
               begin
                  next_rsh  = {rxd_in, rx_shift_reg[7:1]};
                  next_ridx = ridx + 4'h1;
                  if (next_ridx == data_bits(mode_reg[MODE_CHR]))
                     next_rst = (mode_reg[MODE_PE] || mode_reg[MODE_MP])
                                ? R_PAR : R_STOP;
               end
            R_PAR:
               if (rcnt == SAMPLE_PH)
               begin
                  next_rpar = rxd_in;
                  next_rst  = R_STOP;
               end
            R_STOP:
               if (rcnt == SAMPLE_PH)
               begin
                  // Only the first stop bit is tested; back to idle
                  fin      = 1'b1;
                  fin_fer  = !rxd_in;
                  fin_per  = mode_reg[MODE_PE] && !mode_reg[MODE_MP]
                             && (rpar != par_bit(rx_data,
                                  mode_reg[MODE_CHR], mode_reg[MODE_ODD]));
                  next_rst = R_IDLE;
               end
            default:
               next_rst = R_IDLE;
         endcase
      end
   end

   // Receiver registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst          <= R_IDLE;
         rcnt         <= 4'h0;
         ridx         <= 4'h0;
         rx_shift_reg <= 8'h00;
         rpar         <= 1'b0;
      end
      else
      begin
         rst          <= next_rst;
         rcnt         <= next_rcnt;
         ridx         <= next_ridx;
         rx_shift_reg <= next_rsh;
         rpar         <= next_rpar;
      end
   end

   // Bus slave, registers and flags; hardware sets beat clears
   always_comb
   begin
      err_any    = status_reg[STAT_OVERRUN_FLAG] || status_reg[STAT_FER]
                   || status_reg[STAT_PER];
      // One wait cycle per access keeps read data registered
      next_wait  = !((read || write) && waitrequest);
      wr_ok      = write && !waitrequest;
      next_rdata = 32'h0000_0000;
      next_mode  = mode_reg;
      next_rate  = bit_rate_reg;
      next_ctrl  = control_reg;
      next_txbuf = tx_buffer;
      next_rxbuf = rx_buffer;
      next_stat  = status_reg;
      if (read && waitrequest)
         case (address)
            MODE_OFS:  next_rdata[7:0] = mode_reg;
            RATE_OFS:  next_rdata[RATE_W-1:0] = bit_rate_reg;
            CTRL_OFS:  next_rdata[7:0] = control_reg;
            TXBUF_OFS: next_rdata[7:0] = tx_buffer;
            STAT_OFS:  next_rdata[7:0] = status_reg;
            RXBUF_OFS: next_rdata[7:0] = rx_buffer;
            default:   next_rdata = 32'h0000_0000;
         endcase
      if (wr_ok)
         case (address)
            MODE_OFS:  next_mode  = writedata[7:0];
            RATE_OFS:  next_rate  = writedata[RATE_W-1:0];
            CTRL_OFS:  next_ctrl  = writedata[7:0];
            TXBUF_OFS: next_txbuf = writedata[7:0];
            STAT_OFS:
            begin
               // Flags clear on a written 0; the tx mp bit is plain
               next_stat[7:2] = status_reg[7:2] & writedata[7:2];
               next_stat[STAT_MPBT] = writedata[STAT_MPBT];
            end
            default:   next_mode  = mode_reg;
         endcase
      if (!control_reg[CTRL_TE])
         next_stat[STAT_TX_BUF_EMPTY_FLAG] = 1'b1;
      if (take)
      begin
         next_stat[STAT_TX_BUF_EMPTY_FLAG] = 1'b1;
         next_stat[STAT_TX_DONE_FLAG] = 1'b0;
      end
      if (done)
         next_stat[STAT_TX_DONE_FLAG] = 1'b1;
      if (fin)
      begin
         if (status_reg[STAT_RX_FULL_FLAG])
            next_stat[STAT_OVERRUN_FLAG] = 1'b1;
         else
         begin
            next_rxbuf = rx_data;
            next_stat[STAT_MPB]  = rpar && mode_reg[MODE_MP];
            next_stat[STAT_FER]  = status_reg[STAT_FER] || fin_fer;
            next_stat[STAT_PER]  = status_reg[STAT_PER] || fin_per;
            next_stat[STAT_RX_FULL_FLAG] = !fin_fer && !fin_per;
         end
      end
      next_irq_te = next_stat[STAT_TX_BUF_EMPTY_FLAG] && next_ctrl[CTRL_TIE];
      next_irq_td = next_stat[STAT_TX_DONE_FLAG] && next_ctrl[CTRL_TXDONE_IRQ_EN];
      next_irq_rf = next_stat[STAT_RX_FULL_FLAG] && next_ctrl[CTRL_RIE];
      next_irq_re = (next_stat[STAT_OVERRUN_FLAG] || next_stat[STAT_FER]
                     || next_stat[STAT_PER]) && next_ctrl[CTRL_RIE];
      next_txd_oe = next_ctrl[CTRL_TE];
   end

   // Register file and bus registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_reg     <= MODE_RST;
         bit_rate_reg <= RATE_RST[RATE_W-1:0];
         control_reg  <= CTRL_RST;
         tx_buffer    <= 8'h00;
         rx_buffer    <= 8'h00;
         status_reg   <= STAT_RST;
         readdata     <= 32'h0000_0000;
         waitrequest  <= 1'b1;
         tx_empty_irq <= 1'b0;
         tx_end_irq   <= 1'b0;
         rx_full_irq  <= 1'b0;
         rx_error_irq <= 1'b0;
         txd_oe       <= 1'b0;
      end
      else
      begin
         mode_reg     <= next_mode;
         bit_rate_reg <= next_rate;
         control_reg  <= next_ctrl;
         tx_buffer    <= next_txbuf;
         rx_buffer    <= next_rxbuf;
         status_reg   <= next_stat;
         readdata     <= next_rdata;
         waitrequest  <= next_wait;
         tx_empty_irq <= next_irq_te;
         tx_end_irq   <= next_irq_td;
         rx_full_irq  <= next_irq_rf;
         rx_error_irq <= next_irq_re;
         txd_oe       <= next_txd_oe;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_bus_ack: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered in one cycle");
   a_te_off_tx_buf_empty_flag: assert property (!control_reg[CTRL_TE] && !take
                                   |=> status_reg[STAT_TX_BUF_EMPTY_FLAG])
      else $error("tx disable did not set empty flag");
   a_err_halts_rx: assert property (err_any && rst == R_IDLE
                                    |=> rst == R_IDLE)
      else $error("receiver left idle with an error set");
   a_ovr_no_xfer: assert property ($rose(status_reg[STAT_OVERRUN_FLAG])
                                   |-> $stable(rx_buffer))
      else $error("overrun changed receive buffer");
   a_rx_full_flag_clean: assert property ($rose(status_reg[STAT_RX_FULL_FLAG])
                                  |-> !err_any)
      else $error("full flag set beside an error");
   a_sck_unused: assert property (control_reg[1:0] == 2'b00
                                  |=> !sck_oe)
      else $error("clock pin driven while unused");
   a_sck_centre: assert property (tick16 && ph == SAMPLE_PH
                                  |=> ##1 sck_out)
      else $error("output clock low at bit centre");
   a_rxi_request: assert property (status_reg[STAT_RX_FULL_FLAG]
                                   && control_reg[CTRL_RIE] |-> rx_full_irq)
      else $error("receive full interrupt missing");
endmodule : serial_unit
`default_nettype wire

// file: tb/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Remote end; the bench says how many clocks make one bit
module serial_peer (
   input  wire logic       clk,
   input  wire logic       line,
   input  wire logic [5:0] bit_clks,
   output logic            rxd,
   output logic [9:0]      got
);
   // Mark level until the first frame
   initial rxd = 1'b1;
   // Start, eight data bits LSB first, stop (low stop forces an error)
   task automatic send(input logic [7:0] d, input logic stp);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 10; i++)
         repeat (bit_clks) @(posedge clk) rxd <= f[i];
      @(posedge clk) rxd <= 1'b1;
   endtask : send
   // Sample mid-cell after each fall; busy frames ignore inner falls
   always @(negedge line)
   begin
      for (int i = 0; i < 10; i++)
      begin
         repeat (i == 0 ? bit_clks / 2 : bit_clks) @(posedge clk);
         got[i] = line;
      end
   end
endmodule : serial_peer
`default_nettype wire

// file: tb/serial_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
// Register reset values, one frame each way, receive error paths
module serial_unit_test
   import serial_unit_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q;
   logic        waitrequest, txd_out, txd_oe, rxd_in;
   logic        sck_out, sck_oe, prev;
   logic        tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq;
   logic        sck_in = 1'b0;          // Free-running external clock
   logic        port_out_bit = 1'b1;    // Port pin behind the released line
   logic [5:0]  bit_clks = 6'h10;       // Clocks per bit at the far end
   logic [9:0]  got;
   int          rises;
   int          n_errors = 0, checked = 0, cyc = 0;
   // Rows: address and reset value; unmapped slot reads zero
   logic [4:0]  ra [5] = '{MODE_OFS, RATE_OFS, CTRL_OFS, STAT_OFS, 5'h18};
   logic [7:0]  rv [5] = '{MODE_RST, RATE_RST, CTRL_RST, STAT_RST, 8'h00};
   // Released line follows the port pin, high unless a break is sent
   wire         line = txd_oe ? txd_out : port_out_bit;

   // 16x clock: a rise every other cycle, never stopped
   always @(posedge clk) sck_in <= ~sck_in;

   always #12.5 clk = ~clk;

   serial_unit DUT (.clk(clk), .reset_n(reset_n), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .txd_out(txd_out),
      .txd_oe(txd_oe), .rxd_in(rxd_in), .sck_in(sck_in), .sck_out(sck_out),
      .sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq),
      .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
      .tx_end_irq(tx_end_irq));
   serial_peer peer (.clk(clk), .line(line), .bit_clks(bit_clks),
      .rxd(rxd_in), .got(got));

   // Request held until waitrequest is seen low; one idle edge after
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [7:0] d);
      address   <= a;
      writedata <= {24'h0, d};
      read      <= ~w;
      write     <= w;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : bus

   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   // Counts, verdict, end of run
   task automatic results;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   // Hang guard; the whole run needs under two thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         results();
      end
   end

   initial
   begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      foreach (ra[i])
      begin
         bus(1'b0, ra[i], 8'h00);
         chk(q, {24'h0, rv[i]});
      end
      $display("reset values done");
      // Source with enables off, format, rate, one bit time, then enable
      bus(1'b1, CTRL_OFS, 8'h00);
      bus(1'b1, MODE_OFS, 8'h00);
      bus(1'b1, RATE_OFS, 8'h00);
      repeat (16) @(posedge clk);
      bus(1'b1, CTRL_OFS, 8'h30);
      chk(txd_oe, 1'b1);
      // Empty confirmed first; clearing done too makes it meaningful
      bus(1'b0, STAT_OFS, 8'h00);
      chk(q[STAT_TX_BUF_EMPTY_FLAG], 1'b1);
      bus(1'b1, TXBUF_OFS, 8'ha5);
      bus(1'b1, STAT_OFS, 8'h7b);
      do bus(1'b0, STAT_OFS, 8'h00); while (q[STAT_TX_DONE_FLAG] !== 1'b1);
      chk(got, {1'b1, 8'ha5, 1'b0});
      chk(line, 1'b1);
      $display("transmit done");
      peer.send(8'h3c, 1'b1);
      bus(1'b0, STAT_OFS, 8'h00);
      chk(q & 32'h78, 32'h40);
      bus(1'b0, RXBUF_OFS, 8'h00);
      chk(q, 32'h3c);
      // Second frame while still full: overrun, buffer kept
      peer.send(8'h55, 1'b1);
      bus(1'b0, STAT_OFS, 8'h00);
      chk(q & 32'h60, 32'h60);
      bus(1'b0, RXBUF_OFS, 8'h00);
      chk(q, 32'h3c);
      // Low stop bit, then a good frame that must be ignored
      bus(1'b1, STAT_OFS, 8'h84);
      peer.send(8'h99, 1'b0);
      peer.send(8'h11, 1'b1);
      bus(1'b0, STAT_OFS, 8'h00);
      chk(q & 32'h78, 32'h10);
      bus(1'b0, RXBUF_OFS, 8'h00);
      chk(q, 32'h99);
      $display("receive done");
      // Requests follow the flags; a clean frame after the clear
      bus(1'b1, CTRL_OFS, 8'hf4);
      chk(rx_error_irq, 1'b1);
      chk(rx_full_irq, 1'b0);
      chk(tx_empty_irq, 1'b1);
      chk(tx_end_irq, 1'b1);
      bus(1'b1, STAT_OFS, 8'h84);
      peer.send(8'h5a, 1'b1);
      chk(rx_full_irq, 1'b1);
      chk(rx_error_irq, 1'b0);
      $display("interrupts done");
      // Break: port pin low, then disable; receive flags and data kept
      port_out_bit <= 1'b0;
      bus(1'b1, CTRL_OFS, 8'h00);
      chk(txd_oe, 1'b0);
      chk(line, 1'b0);
      port_out_bit <= 1'b1;
      repeat (160) @(posedge clk);
      bus(1'b0, STAT_OFS, 8'h00);
      chk(q & 32'hf8, 32'hc0);
      bus(1'b0, RXBUF_OFS, 8'h00);
      chk(q, 32'h5a);
      $display("disable done");
      // Clock output from the control write alone, one rise per bit
      bus(1'b1, CTRL_OFS, 8'h01);
      repeat (2) @(posedge clk);
      chk(sck_oe, 1'b1);
      prev  = sck_out;
      rises = 0;
      repeat (32)
      begin
         @(posedge clk);
         if (sck_out && !prev)
            rises++;
         prev = sck_out;
      end
      chk(rises, 2);
      // External clock halves the rate; the pin is left to the far end
      bit_clks <= 6'h20;
      bus(1'b1, CTRL_OFS, 8'h02);
      repeat (32) @(posedge clk);
      chk(sck_oe, 1'b0);
      bus(1'b1, CTRL_OFS, 8'h22);
      bus(1'b1, TXBUF_OFS, 8'hc3);
      bus(1'b1, STAT_OFS, 8'h7b);
      do bus(1'b0, STAT_OFS, 8'h00); while (q[STAT_TX_DONE_FLAG] !== 1'b1);
      chk(got, {1'b1, 8'hc3, 1'b0});
      $display("external clock done");
      results();
   end
endmodule : serial_unit_test
`default_nettype wire
